//--- rtl/ibfr_map.svh
// Address map, reset values, field positions and timing counts of the offset bank.
// Included by ibfr_avg_stage, ibfr_top and the bench; definitions only.
`ifndef IBFR_MAP_SVH
`define IBFR_MAP_SVH

// Byte addresses of the register bank (7-bit SPI address)
`define IBFR_OFS_GZ_LO 7'h48
`define IBFR_OFS_GZ_HI 7'h4a
`define IBFR_OFS_AX_LO 7'h4c
`define IBFR_OFS_AX_HI 7'h4e
`define IBFR_OFS_AY_LO 7'h50
`define IBFR_OFS_AY_HI 7'h52
`define IBFR_OFS_AZ_LO 7'h54
`define IBFR_OFS_AZ_HI 7'h56
`define IBFR_OFS_FSIZE 7'h5c

// Reset value of every register
`define IBFR_RST_WORD 16'h0000

// Filter size field position and the mask of its live bits
`define IBFR_FSIZE_MSB 2
`define IBFR_FSIZE_LSB 0
`define IBFR_FSIZE_MASK 16'h0007

// Register count, array index of the filter register, unmapped index
`define IBFR_NREGS 9
`define IBFR_IDX_FSIZE 4'h8
`define IBFR_IDX_NONE 4'hf

// SPI frame: write flag, address and data positions
`define IBFR_FRAME_LAST 5'h0f
`define IBFR_WR_BIT 15
`define IBFR_ADDR_MSB 14
`define IBFR_ADDR_LSB 8

// Averaging stage depth (largest tap count) and accumulator width
`define IBFR_MAX_TAPS 128
`define IBFR_SUM_W 39

// Sample rate of the correction chain and the reference clock rate
`define IBFR_SAMPLE_HZ 2000
`define IBFR_CLK_HZ 25000000
`define IBFR_SAMPLE_DIV (`IBFR_CLK_HZ / `IBFR_SAMPLE_HZ)

`endif

//--- rtl/ibfr_pkg.sv
// Types shared by the offset bank and its averaging stages.
// Assumes nothing beyond a SystemVerilog compiler.
package ibfr_pkg;

	// One 16-bit register word
	typedef logic [15:0] ibfr_word_type;

	// Signed 32-bit sensor value and offset
	typedef logic signed [31:0] ibfr_corr_type;

	// SPI receiver state
	typedef enum logic [0:0] {
		IBFR_IDLE = 1'b0,
		IBFR_SHIFT = 1'b1
	} ibfr_spi_state_type;

endpackage

//--- rtl/ibfr_avg_stage.sv
// One moving-average stage with a power-of-two tap count.
// Assumes in_valid pulses at most once per cycle and clear follows a change of fsize.
`timescale 1ns/1ps
`include "ibfr_map.svh"
module ibfr_avg_stage (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic [2:0] fsize,
	input wire logic in_valid,
	input wire ibfr_pkg::ibfr_corr_type in_data,
	output logic out_valid,
	output ibfr_pkg::ibfr_corr_type out_data
);
	import ibfr_pkg::*;

	ibfr_corr_type hist [`IBFR_MAX_TAPS]; // Sample history, no reset: fill guards it
	logic [6:0] wp; // Next write slot
	logic [6:0] next_wp;
	logic [7:0] fill; // Samples held, saturates at the depth
	logic [7:0] next_fill;
	logic signed [`IBFR_SUM_W-1:0] sum; // Running window sum
	logic signed [`IBFR_SUM_W-1:0] next_sum;
	logic next_out_valid;
	ibfr_corr_type next_out_data;
	logic [7:0] taps; // Window length 2^fsize
	ibfr_corr_type oldest; // Sample leaving the window
	logic signed [`IBFR_SUM_W-1:0] shifted;

	// Window arithmetic; missing samples count as zero while filling
	always_comb begin
		taps = 8'h01 << fsize;
		oldest = hist[wp - taps[6:0]];
		next_wp = wp;
		next_fill = fill;
		next_sum = sum;
		next_out_valid = 1'b0;
		next_out_data = out_data;
		shifted = sum >>> fsize;
		if (clear) begin
			// New size: restart the window rather than mix two lengths
			next_wp = 7'h00;
			next_fill = 8'h00;
			next_sum = '0;
		end else if (in_valid) begin
			next_sum = sum + `IBFR_SUM_W'(in_data);
			if (fill >= taps) begin
				next_sum = next_sum - `IBFR_SUM_W'(oldest);
			end
			next_wp = wp + 7'h01;
			if (fill != 8'h80) begin
				next_fill = fill + 8'h01;
			end
			shifted = next_sum >>> fsize;
			next_out_valid = 1'b1;
			next_out_data = shifted[31:0];
		end
	end

	// State registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wp <= 7'h00;
			fill <= 8'h00;
			sum <= '0;
			out_valid <= 1'b0;
			out_data <= 32'sh0;
		end else begin
			wp <= next_wp;
			fill <= next_fill;
			sum <= next_sum;
			out_valid <= next_out_valid;
			out_data <= next_out_data;
		end
	end

	// History write; the slot read as oldest is overwritten only afterwards
	always_ff @(posedge ref_clk) begin
		if (in_valid && !clear) begin
			hist[wp] <= in_data;
		end
	end

endmodule // ibfr_avg_stage

//--- rtl/ibfr_top.sv
// Bias offset registers, correction adders and two-stage averaging filter for four axes.
// Assumes sclk, cs_n and din are synchronous to ref_clk, sclk at most ref_clk/4, cs_n high between frames.
`timescale 1ns/1ps
`include "ibfr_map.svh"
// Notes on behaviour
// - Gyro z low offset word at 0x48, reset zero
// - Gyro z high offset word at 0x4a, reset zero
// - Gyro z words form one 32-bit offset
// - Gyro z offset applied like gyro x
// - Accel x low offset word at 0x4c, reset zero
// - Accel x high offset word at 0x4e, reset zero
// - Accel x words form 32-bit offset
// - Accel y offset words at 0x50/0x52, reset zero
// - Accel y offset applied like accel x
// - Accel z offset words at 0x54/0x56, reset zero
// - Accel z offset applied like accel x
// - Filter size at 0x5c, bits 2:0, taps 2^B
// - Two cascaded averaging stages, same tap count
// - Correction chain runs at 2000 Hz internally
module ibfr_top #(
	parameter int unsigned SAMPLE_DIV = `IBFR_SAMPLE_DIV // Reference clocks per sample
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	output logic dout,
	input wire ibfr_pkg::ibfr_corr_type raw_gyro_z,
	input wire ibfr_pkg::ibfr_corr_type raw_accel_x,
	input wire ibfr_pkg::ibfr_corr_type raw_accel_y,
	input wire ibfr_pkg::ibfr_corr_type raw_accel_z,
	input wire logic nv_restore,
	input wire logic [143:0] nv_restore_data,
	output logic [143:0] nv_save_data,
	output ibfr_pkg::ibfr_corr_type filt_gyro_z,
	output ibfr_pkg::ibfr_corr_type filt_accel_x,
	output ibfr_pkg::ibfr_corr_type filt_accel_y,
	output ibfr_pkg::ibfr_corr_type filt_accel_z,
	output logic filt_valid,
	output logic sample_tick
);
	import ibfr_pkg::*;

	// Map a byte address to a register index
	function automatic logic [3:0] reg_index(input logic [6:0] addr);
		logic [6:0] word_addr;
		word_addr = {addr[6:1], 1'b0};
		unique case (word_addr)
			`IBFR_OFS_GZ_LO: reg_index = 4'h0;
			`IBFR_OFS_GZ_HI: reg_index = 4'h1;
			`IBFR_OFS_AX_LO: reg_index = 4'h2;
			`IBFR_OFS_AX_HI: reg_index = 4'h3;
			`IBFR_OFS_AY_LO: reg_index = 4'h4;
			`IBFR_OFS_AY_HI: reg_index = 4'h5;
			`IBFR_OFS_AZ_LO: reg_index = 4'h6;
			`IBFR_OFS_AZ_HI: reg_index = 4'h7;
			`IBFR_OFS_FSIZE: reg_index = `IBFR_IDX_FSIZE;
			default: reg_index = `IBFR_IDX_NONE;
		endcase
	endfunction

	// SPI receiver state
	ibfr_spi_state_type spi_state;
	ibfr_spi_state_type next_spi_state;
	logic sclk_prev; // Last sampled sclk, for edge detection
	logic next_sclk_prev;
	logic [4:0] bit_cnt; // Bits taken in this frame
	logic [4:0] next_bit_cnt;
	ibfr_word_type shin; // Incoming command word
	ibfr_word_type next_shin;
	ibfr_word_type shout; // Outgoing read answer
	ibfr_word_type next_shout;
	logic next_dout;
	logic frame_done; // One-cycle pulse per complete frame
	logic next_frame_done;
	ibfr_word_type frame_word; // Completed frame
	ibfr_word_type next_frame_word;

	// Register bank and read answer
	ibfr_word_type regs [`IBFR_NREGS];
	ibfr_word_type next_regs [`IBFR_NREGS];
	ibfr_word_type rd_word; // Answer shifted out in the next frame
	ibfr_word_type next_rd_word;
	logic [3:0] frame_idx;

	// Sample timing and correction
	logic [15:0] tick_cnt;
	logic [15:0] next_tick_cnt;
	logic next_sample_tick;
	ibfr_corr_type raw [4];
	ibfr_corr_type corr [4]; // Offset-corrected samples
	ibfr_corr_type next_corr [4];
	logic corr_valid;
	logic next_corr_valid;
	logic [2:0] fsize_prev; // Filter size seen last cycle
	logic filt_clear; // Restart both stages after a size change
	logic next_filt_clear;
	ibfr_corr_type s1_out [4];
	logic [3:0] s1_valid;
	ibfr_corr_type s2_out [4];
	logic [3:0] s2_valid;

	// SPI frame receiver; a frame cut short by cs_n is dropped
	always_comb begin
		next_spi_state = spi_state;
		next_sclk_prev = sclk;
		next_bit_cnt = bit_cnt;
		next_shin = shin;
		next_shout = shout;
		next_dout = shout[15];
		next_frame_done = 1'b0;
		next_frame_word = frame_word;
		unique case (spi_state)
			IBFR_IDLE: begin
				// Preload the pending answer before the frame starts
				next_shout = rd_word;
				next_bit_cnt = 5'h00;
				if (!cs_n) begin
					next_spi_state = IBFR_SHIFT;
				end
			end
			IBFR_SHIFT: begin
				if (cs_n) begin
					next_spi_state = IBFR_IDLE;
				end else if (sclk && !sclk_prev) begin
					// Rising edge: take din
					next_shin = {shin[14:0], din};
					next_bit_cnt = bit_cnt + 5'h01;
					if (bit_cnt == `IBFR_FRAME_LAST) begin
						next_frame_done = 1'b1;
						next_frame_word = {shin[14:0], din};
						next_bit_cnt = 5'h00;
					end
				end else if (!sclk && sclk_prev) begin
					// Falling edge: present the next answer bit
					next_shout = {shout[14:0], 1'b0};
				end
			end
		endcase
	end

	// SPI registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			spi_state <= IBFR_IDLE;
			sclk_prev <= 1'b1;
			bit_cnt <= 5'h00;
			shin <= 16'h0000;
			shout <= 16'h0000;
			dout <= 1'b0;
			frame_done <= 1'b0;
			frame_word <= 16'h0000;
		end else begin
			spi_state <= next_spi_state;
			sclk_prev <= next_sclk_prev;
			bit_cnt <= next_bit_cnt;
			shin <= next_shin;
			shout <= next_shout;
			dout <= next_dout;
			frame_done <= next_frame_done;
			frame_word <= next_frame_word;
		end
	end

	// Register writes, reads and backup restore
	always_comb begin
		frame_idx = reg_index(frame_word[`IBFR_ADDR_MSB:`IBFR_ADDR_LSB]);
		next_regs = regs;
		next_rd_word = rd_word;
		if (nv_restore) begin
			// Restore wins over a frame landing in the same cycle
			for (int i = 0; i < `IBFR_NREGS; i++) begin
				next_regs[i] = nv_restore_data[i*16 +: 16];
			end
		end else if (frame_done && frame_word[`IBFR_WR_BIT]) begin
			// Byte write: even address low byte, odd address high byte
			if (frame_idx != `IBFR_IDX_NONE) begin
				if (frame_word[`IBFR_ADDR_LSB]) begin
					next_regs[frame_idx][15:8] = frame_word[7:0];
				end else begin
					next_regs[frame_idx][7:0] = frame_word[7:0];
				end
			end
		end else if (frame_done) begin
			// Read: unmapped addresses answer zero
			next_rd_word = (frame_idx == `IBFR_IDX_NONE) ? 16'h0000 : regs[frame_idx];
		end
		// Unused filter bits hold zero
		next_regs[`IBFR_IDX_FSIZE] = next_regs[`IBFR_IDX_FSIZE] & `IBFR_FSIZE_MASK;
	end

	// Register bank storage
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int i = 0; i < `IBFR_NREGS; i++) begin
				regs[i] <= `IBFR_RST_WORD;
			end
			rd_word <= 16'h0000;
		end else begin
			regs <= next_regs;
			rd_word <= next_rd_word;
		end
	end

	// Backup image is the live bank, register 0 in the low bits
	always_comb begin
		for (int i = 0; i < `IBFR_NREGS; i++) begin
			nv_save_data[i*16 +: 16] = regs[i];
		end
	end

	// Sample timer, offset adders and size-change detection
	always_comb begin
		raw[0] = raw_gyro_z;
		raw[1] = raw_accel_x;
		raw[2] = raw_accel_y;
		raw[3] = raw_accel_z;
		next_tick_cnt = tick_cnt + 16'h0001;
		next_sample_tick = 1'b0;
		if (tick_cnt == 16'(SAMPLE_DIV - 1)) begin
			next_tick_cnt = 16'h0000;
			next_sample_tick = 1'b1;
		end
		next_corr = corr;
		next_corr_valid = sample_tick;
		for (int c = 0; c < 4; c++) begin
			// Same adder for every axis; high word supplies bits 31:16
			if (sample_tick) begin
				next_corr[c] = raw[c] + $signed({regs[2*c+1], regs[2*c]});
			end
		end
		next_filt_clear = (regs[`IBFR_IDX_FSIZE][2:0] != fsize_prev);
	end

	// Timer and correction registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tick_cnt <= 16'h0000;
			sample_tick <= 1'b0;
			corr_valid <= 1'b0;
			fsize_prev <= 3'h0;
			filt_clear <= 1'b0;
			for (int c = 0; c < 4; c++) begin
				corr[c] <= 32'sh0;
			end
		end else begin
			tick_cnt <= next_tick_cnt;
			sample_tick <= next_sample_tick;
			corr_valid <= next_corr_valid;
			fsize_prev <= regs[`IBFR_IDX_FSIZE][2:0];
			filt_clear <= next_filt_clear;
			corr <= next_corr;
		end
	end

	// Two cascaded stages per axis, both sized by the same field
	for (genvar c = 0; c < 4; c++) begin : g_axis
		ibfr_avg_stage u_first (
			.ref_clk(ref_clk),
			.rst(rst),
			.clear(filt_clear),
			.fsize(regs[`IBFR_IDX_FSIZE][`IBFR_FSIZE_MSB:`IBFR_FSIZE_LSB]),
			.in_valid(corr_valid),
			.in_data(corr[c]),
			.out_valid(s1_valid[c]),
			.out_data(s1_out[c])
		);
		ibfr_avg_stage u_second (
			.ref_clk(ref_clk),
			.rst(rst),
			.clear(filt_clear),
			.fsize(regs[`IBFR_IDX_FSIZE][`IBFR_FSIZE_MSB:`IBFR_FSIZE_LSB]),
			.in_valid(s1_valid[c]),
			.in_data(s1_out[c]),
			.out_valid(s2_valid[c]),
			.out_data(s2_out[c])
		);
	end

	// Filter outputs come from the second-stage flops
	assign filt_gyro_z = s2_out[0];
	assign filt_accel_x = s2_out[1];
	assign filt_accel_y = s2_out[2];
	assign filt_accel_z = s2_out[3];
	assign filt_valid = s2_valid[0];

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// Low byte write lands in the addressed register
	property wr_low_p(logic [6:0] a, int idx);
		frame_done && frame_word[15] && !nv_restore && frame_word[14:8] == a |=>
			regs[idx][7:0] == $past(frame_word[7:0]);
	endproperty

	// Correction is raw plus the 32-bit offset of the same axis
	property corr_p(int c);
		sample_tick |=> corr_valid && corr[c] == $past(raw[c]) + $signed($past({regs[2*c+1], regs[2*c]}));
	endproperty

	gz_low_wr_a: assert property (wr_low_p(`IBFR_OFS_GZ_LO, 0))
		else $error("gyro z low word write lost");
	gz_high_wr_a: assert property (wr_low_p(`IBFR_OFS_GZ_HI, 1))
		else $error("gyro z high word write lost");
	ax_low_wr_a: assert property (wr_low_p(`IBFR_OFS_AX_LO, 2))
		else $error("accel x low word write lost");
	ax_high_wr_a: assert property (frame_done && frame_word[15] && !nv_restore && frame_word[14:8] == 7'h4f
		|=> regs[3][15:8] == $past(frame_word[7:0]))
		else $error("accel x high byte write lost");
	ay_low_wr_a: assert property (wr_low_p(`IBFR_OFS_AY_LO, 4))
		else $error("accel y low word write lost");
	az_low_wr_a: assert property (wr_low_p(`IBFR_OFS_AZ_LO, 6))
		else $error("accel z low word write lost");
	fsize_mask_a: assert property (regs[8][15:3] == 13'h0000)
		else $error("filter register unused bits set");
	gz_corr_a: assert property (corr_p(0))
		else $error("gyro z correction wrong");
	ax_corr_a: assert property (corr_p(1))
		else $error("accel x correction wrong");
	ay_corr_a: assert property (corr_p(2))
		else $error("accel y correction wrong");
	az_corr_a: assert property (corr_p(3))
		else $error("accel z correction wrong");
	// A restart in either stage's input cycle drops that sample, so both cycles must be clear
	chain_lat_a: assert property (corr_valid && !filt_clear ##1 !filt_clear |=> filt_valid)
		else $error("filter output not two cycles after correction");
	tick_gap_a: assert property (sample_tick |=> !sample_tick ##0 tick_cnt == 16'h0001)
		else $error("sample tick spacing wrong");
	nv_load_a: assert property (nv_restore |=> nv_save_data[127:0] == $past(nv_restore_data[127:0]))
		else $error("backup restore not applied");

	wr_frame_c: cover property (frame_done && frame_word[15]);
	rd_frame_c: cover property (frame_done && !frame_word[15] ##1 spi_state == IBFR_SHIFT);
	filt_big_c: cover property (filt_valid && regs[8][2:0] == 3'h7);
	size_change_c: cover property (filt_clear);

endmodule // ibfr_top

//--- verification/ibfr_spi_host.sv
// Host side of the offset bank: an SPI master that sends sixteen-bit frames.
// Assumes ref_clk is the bank's clock and the bank shifts dout on falling sclk.
`timescale 1ns/1ps
module ibfr_spi_host (
	input wire logic ref_clk,
	input wire logic dout,
	output logic sclk,
	output logic cs_n,
	output logic din
);
	// Idle: clock high, deselected
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din = 1'b0;
	end

	// One frame, MSB first; four-clock halves leave margin over the two-clock minimum
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		rx = 16'h0000;
		@(posedge ref_clk);
		cs_n <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			@(posedge ref_clk);
			// Top answer bit stands from selection until the first falling edge
			if (i == 15)
				rx[15] = dout;
			sclk <= 1'b0;
			din <= tx[i];
			repeat (4) @(posedge ref_clk);
			// Every falling edge, the first too, moves the answer on by one bit
			if (i > 0)
				rx[i - 1] = dout;
			sclk <= 1'b1;
			repeat (3) @(posedge ref_clk);
		end
		cs_n <= 1'b1;
		// Released line shows the inverse, so a stale bit is never mistaken for data
		din <= ~tx[0];
		repeat (4) @(posedge ref_clk);
	endtask
endmodule // ibfr_spi_host

//--- verification/ibfr_bench.sv
// Self-checking bench of the offset bank: registers, corrections, filter, timing, backup.
// Assumes the SPI host model beside it and a sample divider of 16.
`timescale 1ns/1ps
`include "ibfr_map.svh"
module ibfr_bench;
	import ibfr_pkg::*;
	logic ref_clk, rst, sclk, cs_n, din, dout, nv_restore, filt_valid, sample_tick;
	ibfr_corr_type raw[4]; // Raw samples per axis
	ibfr_corr_type filt[4]; // Filtered outputs per axis
	logic [143:0] nv_restore_data, nv_save_data;
	int mismatches = 0;
	int n_compared = 0;
	ibfr_word_type rd; // Last word read back
	// Bank addresses in backup-image order
	logic [6:0] addr_tab[9] = '{`IBFR_OFS_GZ_LO, `IBFR_OFS_GZ_HI, `IBFR_OFS_AX_LO, `IBFR_OFS_AX_HI,
		`IBFR_OFS_AY_LO, `IBFR_OFS_AY_HI, `IBFR_OFS_AZ_LO, `IBFR_OFS_AZ_HI, `IBFR_OFS_FSIZE};
	// Offsets with both signs, so the high word's sign reaches the sum
	ibfr_corr_type off[4] = '{32'hffff_fff0, 32'h0001_8000, 32'hfffe_7fff, 32'h0000_0123};

	// Short divider keeps the run brief
	ibfr_top #(.SAMPLE_DIV(16)) uut (.ref_clk(ref_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
		.dout(dout), .raw_gyro_z(raw[0]), .raw_accel_x(raw[1]), .raw_accel_y(raw[2]), .raw_accel_z(raw[3]),
		.nv_restore(nv_restore), .nv_restore_data(nv_restore_data), .nv_save_data(nv_save_data),
		.filt_gyro_z(filt[0]), .filt_accel_x(filt[1]), .filt_accel_y(filt[2]), .filt_accel_z(filt[3]),
		.filt_valid(filt_valid), .sample_tick(sample_tick));

	ibfr_spi_host host (.ref_clk(ref_clk), .dout(dout), .sclk(sclk), .cs_n(cs_n), .din(din));

	// 25 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// Comparison with case inequality, so unknowns never match
	task automatic check(input logic [143:0] seen, input logic [143:0] want);
		n_compared++;
		if (seen !== want) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Word write: low byte at the even address, high byte at the odd one
	task automatic wr(input logic [6:0] a, input ibfr_word_type v);
		logic [15:0] x;
		host.xfer({1'b1, a, v[7:0]}, x);
		host.xfer({1'b1, a | 7'h01, v[15:8]}, x);
	endtask

	// Word read: answer arrives in the following frame
	task automatic rdw(input logic [6:0] a, output ibfr_word_type v);
		host.xfer({1'b0, a, 8'h00}, v);
		host.xfer(16'h0000, v);
	endtask

	// Next filter update, bounded
	task automatic wait_valid;
		int n;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
			if (n > 40) begin
				mismatches++;
				conclude();
			end
		end while (filt_valid !== 1'b1);
	endtask

	function automatic ibfr_word_type pat(input int i);
		return {4'(i), 12'h3c5} ^ 16'h8000;
	endfunction

	// All registers read zero after reset
	task automatic t_reset;
		for (int i = 0; i < 9; i++) begin
			rdw(addr_tab[i], rd);
			check(rd, `IBFR_RST_WORD);
		end
		check(nv_save_data, 144'h0);
	endtask

	// Every word read back; unused filter bits and a hole in the map stay zero
	task automatic t_regs;
		for (int i = 0; i < 8; i++)
			wr(addr_tab[i], pat(i));
		wr(`IBFR_OFS_FSIZE, 16'hfffd);
		wr(7'h5a, 16'hbeef);
		for (int i = 0; i < 9; i++) begin
			rdw(addr_tab[i], rd);
			check(rd, (i < 8) ? pat(i) : 16'h0005);
			check(nv_save_data[16 * i +: 16], (i < 8) ? pat(i) : 16'h0005);
		end
		rdw(7'h5a, rd);
		check(rd, 16'h0000);
	endtask

	// One tap: output is raw plus the signed 32-bit offset
	task automatic t_corr;
		wr(`IBFR_OFS_FSIZE, 16'h0000);
		for (int k = 0; k < 4; k++) begin
			wr(addr_tab[2 * k], off[k][15:0]);
			wr(addr_tab[2 * k + 1], off[k][31:16]);
		end
		@(posedge ref_clk);
		for (int k = 0; k < 4; k++)
			raw[k] <= 32'h0010_0000 * (k + 1);
		repeat (3) wait_valid();
		for (int k = 0; k < 4; k++)
			// Cut to 32 bits, else the wide compare keeps the carry out of a negative offset
			check(filt[k], 32'(32'h0010_0000 * (k + 1) + off[k]));
	endtask

	// Step response of two cascaded 2^b-tap averages on the gyro axis
	task automatic t_filter(input int b);
		int s1[8];
		int e;
		wr(`IBFR_OFS_FSIZE, 16'(b));
		@(posedge ref_clk);
		raw[0] <= -off[0];
		// Flush both windows with zeros; one older sample may still be in flight
		repeat (2 << b) wait_valid();
		@(posedge ref_clk);
		raw[0] <= 32'h0000_1000 - off[0];
		for (int k = 0; k < 7; k++) begin
			s1[k] = (4096 * ((k + 1 < (1 << b)) ? k + 1 : (1 << b))) >>> b;
			e = 0;
			for (int j = 0; j < (1 << b) && j <= k; j++)
				e += s1[k - j];
			wait_valid();
			check(filt[0], 32'(e >>> b));
		end
	endtask

	// Tick spacing and pipeline depth of the sample chain
	task automatic t_tick;
		int n;
		n = 0;
		while (sample_tick !== 1'b1 && n < 40) begin
			@(negedge ref_clk);
			n++;
		end
		// No tick at all is a hang, not a spacing error
		if (sample_tick !== 1'b1) begin
			mismatches++;
			conclude();
		end
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (filt_valid !== 1'b1 && n < 40);
		check(n, 3);
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (sample_tick !== 1'b1 && n < 40);
		check(n, 13);
	endtask

	// Restore from backup, then a reset in mid-run clears the bank
	task automatic t_nv;
		@(posedge ref_clk);
		nv_restore_data <= {16'h0003, 128'h8001_7ffe_1234_fedc_0f0f_f0f0_aaaa_5555};
		nv_restore <= 1'b1;
		@(posedge ref_clk);
		nv_restore <= 1'b0;
		repeat (3) @(posedge ref_clk);
		check(nv_save_data, {16'h0003, 128'h8001_7ffe_1234_fedc_0f0f_f0f0_aaaa_5555});
		rdw(`IBFR_OFS_GZ_HI, rd);
		check(rd, 16'haaaa);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(negedge ref_clk);
		check(nv_save_data, 144'h0);
	endtask

	// Main sequence
	initial begin
		rst <= 1'b1;
		nv_restore <= 1'b0;
		nv_restore_data <= 144'h0;
		for (int k = 0; k < 4; k++)
			raw[k] <= 32'h0;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		t_reset();
		t_regs();
		t_corr();
		t_filter(1);
		t_filter(3);
		t_tick();
		t_nv();
		conclude();
	end
endmodule // ibfr_bench
